/* hw/cond_jump_decode_adc_pkg.sv */
// Package for the condition and add-with-carry decode block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package cond_jump_decode_adc_pkg;

    // Register byte offsets
    localparam logic [7:0] OPCODE_OFFSET  = 8'h00;
    localparam logic [7:0] DST_OFFSET     = 8'h04;
    localparam logic [7:0] SRC_OFFSET     = 8'h08;
    localparam logic [7:0] FLAGS_OFFSET   = 8'h0C;
    localparam logic [7:0] RESULT_OFFSET  = 8'h10;
    localparam logic [7:0] DECODE_OFFSET  = 8'h14;

    // Flag bit positions in the flags register
    localparam int FLAG_C_BIT = 7;
    localparam int FLAG_Z_BIT = 6;
    localparam int FLAG_S_BIT = 5;
    localparam int FLAG_V_BIT = 4;
    localparam int FLAG_D_BIT = 3;
    localparam int FLAG_H_BIT = 2;

    // Decode status field positions
    localparam int DEC_CLASS_LSB   = 0;
    localparam int DEC_TAKEN_BIT   = 5;
    localparam int DEC_SRCFST_BIT  = 6;
    localparam int DEC_BYTES_LSB   = 8;
    localparam int DEC_CYCLES_LSB  = 12;

    // Reset values
    localparam logic [7:0]  OPCODE_RESET = 8'hFF;
    localparam logic [7:0]  DATA_RESET   = 8'h00;
    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam logic [15:0] DECODE_RESET = 16'h0000;

    // Add-with-carry opcodes and their size and timing
    localparam logic [7:0] ADC_RR_OP   = 8'h12;
    localparam logic [7:0] ADC_RIR_OP  = 8'h13;
    localparam logic [7:0] ADC_GG_OP   = 8'h14;
    localparam logic [7:0] ADC_GIG_OP  = 8'h15;
    localparam logic [7:0] ADC_GIM_OP  = 8'h16;
    localparam logic [1:0] ADC_SHORT_BYTES  = 2'h2;
    localparam logic [3:0] ADC_SHORT_CYCLES = 4'h6;
    localparam logic [1:0] ADC_LONG_BYTES   = 2'h3;
    localparam logic [3:0] ADC_LONG_CYCLES  = 4'hA;

    // Condition codes
    localparam logic [3:0] CC_NEVER        = 4'h0;
    localparam logic [3:0] CC_SIGNED_BELOW = 4'h1;
    localparam logic [3:0] CC_SIGNED_ATMOST= 4'h2;
    localparam logic [3:0] CC_UNS_ATMOST   = 4'h3;
    localparam logic [3:0] CC_VFLAG_SET    = 4'h4;
    localparam logic [3:0] CC_SIGN_SET     = 4'h5;
    localparam logic [3:0] CC_ZERO_SET     = 4'h6;
    localparam logic [3:0] CC_CARRY_SET    = 4'h7;
    localparam logic [3:0] CC_ALWAYS       = 4'h8;
    localparam logic [3:0] CC_SIGNED_ATLST = 4'h9;
    localparam logic [3:0] CC_SIGNED_ABOVE = 4'hA;
    localparam logic [3:0] CC_UNS_ABOVE    = 4'hB;
    localparam logic [3:0] CC_VFLAG_CLEAR  = 4'hC;
    localparam logic [3:0] CC_SIGN_CLEAR   = 4'hD;
    localparam logic [3:0] CC_ZERO_CLEAR   = 4'hE;
    localparam logic [3:0] CC_CARRY_CLEAR  = 4'hF;

    // Decoded operation classes
    typedef enum logic [4:0] {
        OP_OTHER, OP_MOVE_REG_R1_R2, OP_MOVE_REG_R2_R1, OP_DECREMENT_BRANCH_NONZERO,
        OP_SHORT_BRANCH, OP_MOVE_REG_R1_IM, OP_ABSOLUTE_BRANCH, OP_BUMP_REG,
        OP_NEXT, OP_ENTER, OP_EXIT, OP_WAIT_FOR_INTERRUPT, OP_BANK0_SELECT,
        OP_BANK1_SELECT, OP_IDLE, OP_STOP, OP_MASK_INTERRUPTS, OP_UNMASK_INTERRUPTS,
        OP_POP_PC_BACK, OP_ISR_EXIT, OP_CARRY_CLEAR_OP, OP_CARRY_SET_OP,
        OP_CARRY_FLIP_OP, OP_NO_OPERATION, OP_ADD_WITH_CARRY
    } op_type;

endpackage

/* hw/cond_jump_decode_adc.sv */
// Decode and execute for columns 8 to F, condition evaluation and add with carry.
// Assumes a classic Wishbone master on the same clock; operands already fetched.
//
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module cond_jump_decode_adc (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             jump_taken
);
    import cond_jump_decode_adc_pkg::*;

    logic [7:0]  opcode_reg, opcode_next;
    logic [7:0]  dst_reg, dst_next;
    logic [7:0]  src_reg, src_next;
    logic [7:0]  flags_reg, flags_next;
    logic [7:0]  result_reg, result_next;
    logic [15:0] decode_reg, decode_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        ack_reg, ack_next;
    logic        taken_reg, taken_next;

    // Condition evaluation against live flags
    function automatic logic cond_true(input logic [3:0] cc, input logic [7:0] f);
        logic c;
        logic z;
        logic s;
        logic v;
        logic r;
        c = f[FLAG_C_BIT];
        z = f[FLAG_Z_BIT];
        s = f[FLAG_S_BIT];
        v = f[FLAG_V_BIT];
        case (cc)
            CC_NEVER:         r = 1'b0;
            CC_ALWAYS:        r = 1'b1;
            CC_CARRY_SET:     r = c;
            CC_CARRY_CLEAR:   r = ~c;
            CC_SIGN_SET:      r = s;
            CC_SIGN_CLEAR:    r = ~s;
            CC_VFLAG_SET:     r = v;
            CC_VFLAG_CLEAR:   r = ~v;
            CC_ZERO_SET:      r = z;
            CC_ZERO_CLEAR:    r = ~z;
            CC_SIGNED_ATLST:  r = ~(s ^ v);
            CC_SIGNED_BELOW:  r = s ^ v;
            CC_SIGNED_ABOVE:  r = ~(z | (s ^ v));
            CC_SIGNED_ATMOST: r = z | (s ^ v);
            CC_UNS_ABOVE:     r = ~c & ~z;
            CC_UNS_ATMOST:    r = c | z;
            default:          r = 1'b0;
        endcase
        return r;
    endfunction

    // Opcode class decode
    function automatic op_type decode_op(input logic [7:0] op);
        op_type t;
        t = OP_OTHER;
        case (op[3:0])
            4'h8: t = OP_MOVE_REG_R1_R2;
            4'h9: t = OP_MOVE_REG_R2_R1;
            4'hA: t = OP_DECREMENT_BRANCH_NONZERO;
            4'hB: t = OP_SHORT_BRANCH;
            4'hC: t = OP_MOVE_REG_R1_IM;
            4'hD: t = OP_ABSOLUTE_BRANCH;
            4'hE: t = OP_BUMP_REG;
            4'hF: t = op_type'(5'(OP_NEXT) + {1'b0, op[7:4]});
            default: begin
                if (op >= ADC_RR_OP && op <= ADC_GIM_OP) begin
                    t = OP_ADD_WITH_CARRY;
                end
            end
        endcase
        return t;
    endfunction

    // Bus slave, decode and execute next state
    always_comb begin
        logic       sel_hit;
        logic       wr;
        logic       rd_en;
        logic       cin;
        logic [8:0] sum9;
        logic [4:0] low5;
        logic [7:0] res;
        op_type     cls;
        sel_hit     = wb_cyc_i & wb_stb_i & ~ack_reg;
        wr          = sel_hit & wb_we_i & wb_sel_i[0];
        rd_en       = sel_hit & ~wb_we_i;
        opcode_next = opcode_reg;
        dst_next    = dst_reg;
        src_next    = src_reg;
        flags_next  = flags_reg;
        result_next = result_reg;
        decode_next = decode_reg;
        taken_next  = taken_reg;
        rdata_next  = rdata_reg;
        ack_next    = sel_hit;
        cin         = flags_reg[FLAG_C_BIT];
        sum9        = {1'b0, dst_reg} + {1'b0, src_reg} + {8'h00, cin};
        low5        = {1'b0, dst_reg[3:0]} + {1'b0, src_reg[3:0]} + {4'h0, cin};
        res         = sum9[7:0];
        cls         = decode_op(wb_dat_i[7:0]);

        // Register writes
        if (wr) begin
            case (wb_adr_i)
                DST_OFFSET:   dst_next   = wb_dat_i[7:0];
                SRC_OFFSET:   src_next   = wb_dat_i[7:0];
                FLAGS_OFFSET: flags_next = wb_dat_i[7:0];
                default:      ;
            endcase
        end

        // Opcode write executes with flags as they stand now
        if (wr && wb_adr_i == OPCODE_OFFSET) begin
            opcode_next = wb_dat_i[7:0];
            decode_next = DECODE_RESET;
            decode_next[DEC_CLASS_LSB +: 5] = 5'(cls);
            taken_next  = 1'b0;
            if (cls == OP_SHORT_BRANCH || cls == OP_ABSOLUTE_BRANCH) begin
                taken_next = cond_true(wb_dat_i[7:4], flags_reg);
            end
            decode_next[DEC_TAKEN_BIT] = taken_next;
            case (cls)
                OP_ADD_WITH_CARRY: begin
                    dst_next    = res;
                    result_next = res;
                    flags_next[FLAG_C_BIT] = sum9[8];
                    flags_next[FLAG_Z_BIT] = (res == 8'h00);
                    flags_next[FLAG_S_BIT] = res[7];
                    flags_next[FLAG_D_BIT] = 1'b0;
                    flags_next[FLAG_V_BIT] = (dst_reg[7] == src_reg[7]) && (res[7] != dst_reg[7]);
                    flags_next[FLAG_H_BIT] = low5[4];
                    if (wb_dat_i[7:0] <= ADC_RIR_OP) begin
                        decode_next[DEC_BYTES_LSB +: 2]  = ADC_SHORT_BYTES;
                        decode_next[DEC_CYCLES_LSB +: 4] = ADC_SHORT_CYCLES;
                    end else begin
                        decode_next[DEC_BYTES_LSB +: 2]  = ADC_LONG_BYTES;
                        decode_next[DEC_CYCLES_LSB +: 4] = ADC_LONG_CYCLES;
                        decode_next[DEC_SRCFST_BIT] = (wb_dat_i[7:0] != ADC_GIM_OP);
                    end
                end
                OP_CARRY_CLEAR_OP: flags_next[FLAG_C_BIT] = 1'b0;
                OP_CARRY_SET_OP:   flags_next[FLAG_C_BIT] = 1'b1;
                OP_CARRY_FLIP_OP:  flags_next[FLAG_C_BIT] = ~flags_reg[FLAG_C_BIT];
                default:           ;
            endcase
        end

        // Read data, zero for unmapped offsets
        if (rd_en) begin
            case (wb_adr_i)
                OPCODE_OFFSET: rdata_next = {24'h000000, opcode_reg};
                DST_OFFSET:    rdata_next = {24'h000000, dst_reg};
                SRC_OFFSET:    rdata_next = {24'h000000, src_reg};
                FLAGS_OFFSET:  rdata_next = {24'h000000, flags_reg};
                RESULT_OFFSET: rdata_next = {24'h000000, result_reg};
                DECODE_OFFSET: rdata_next = {16'h0000, decode_reg};
                default:       rdata_next = 32'h00000000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            opcode_reg <= OPCODE_RESET;
            dst_reg    <= DATA_RESET;
            src_reg    <= DATA_RESET;
            flags_reg  <= FLAGS_RESET;
            result_reg <= DATA_RESET;
            decode_reg <= DECODE_RESET;
            rdata_reg  <= 32'h00000000;
            ack_reg    <= 1'b0;
            taken_reg  <= 1'b0;
        end else begin
            opcode_reg <= opcode_next;
            dst_reg    <= dst_next;
            src_reg    <= src_next;
            flags_reg  <= flags_next;
            result_reg <= result_next;
            decode_reg <= decode_next;
            rdata_reg  <= rdata_next;
            ack_reg    <= ack_next;
            taken_reg  <= taken_next;
        end
    end

    // Outputs straight from flip-flops
    assign wb_dat_o   = rdata_reg;
    assign wb_ack_o   = ack_reg;
    assign jump_taken = taken_reg;

endmodule // cond_jump_decode_adc

/* sim/cond_jump_decode_adc_chk.sv */
// Checker for the bus answer and the jump output of the decode block.
// Assumes a bind onto the top module; sees its ports only.
`timescale 1ns/1ps
module cond_jump_decode_adc_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        jump_taken
);
    import cond_jump_decode_adc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic req;
    logic op_wr;
    logic br;
    // Taken request, opcode write and branch column
    assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign op_wr = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == OPCODE_OFFSET);
    assign br    = (wb_dat_i[3:0] == 4'hB) | (wb_dat_i[3:0] == 4'hD);
    a_ack_answer: assert property (req |=> wb_ack_o) else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
    a_jump_hold: assert property ($changed(jump_taken) |-> $past(op_wr) || $past(rst))
        else $error("jump output moved without opcode write");
    a_jump_column: assert property ($rose(jump_taken) |-> $past(br))
        else $error("jump raised outside branch column");
    a_never_jump: assert property (op_wr && br && wb_dat_i[7:4] == 4'h0 |=> !jump_taken)
        else $error("never condition jumped");
    a_always_jump: assert property (op_wr && br && wb_dat_i[7:4] == 4'h8 |=> jump_taken)
        else $error("always condition did not jump");
    a_other_clear: assert property (op_wr && !br |=> !jump_taken)
        else $error("non-branch opcode jumped");
    a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    c_jump: cover property (op_wr && br ##1 jump_taken);
    c_adc: cover property (op_wr && wb_dat_i[7:0] == ADC_GIM_OP);
    c_read: cover property (wb_ack_o && !wb_we_i);
endmodule // cond_jump_decode_adc_chk

/* sim/cond_jump_decode_adc_tb.sv */
// Self-checking bench: bus tasks, condition model and add-with-carry model.
// Assumes the checker file is compiled before this one.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module cond_jump_decode_adc_tb;
    import cond_jump_decode_adc_pkg::*;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, r;
    logic        ack, jump_taken;
    int n_errors = 0, num_checks = 0;
    logic [7:0] f, d, s, op, sum, ef;
    logic [4:0] cls;
    logic       j, c9;
    cond_jump_decode_adc uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .jump_taken(jump_taken));
    // Clock, 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end
    // One classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v, input logic s0);
        int t;
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, v}; sel <= s0 ? 4'hF : 4'h0;
        @(posedge clk);
        for (t = 0; t < 20 && ack !== 1'b1; t++) @(posedge clk);
        r = dat_o;
        cyc <= 0; stb <= 0;
        @(posedge clk);
    endtask
    // Condition model over C Z S V
    function automatic logic cond(input logic [3:0] cc, input logic [7:0] fl);
        logic [7:0] t;
        // Index by low three code bits: 7 C, 6 Z, 5 S, 4 V, 3 C|Z, 2 Z|(S^V), 1 S^V, 0 false
        t = {fl[7], fl[6], fl[5], fl[4], fl[7] | fl[6], fl[6] | (fl[5] ^ fl[4]), fl[5] ^ fl[4], 1'b0};
        return cc[3] ^ t[cc[2:0]];
    endfunction
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog
    initial begin
        #(40000 * 100);
        n_errors++;
        summarize();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hd97e));
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        wb(0, OPCODE_OFFSET, 0, 1); `CHK(r[7:0], OPCODE_RESET)
        wb(0, DECODE_OFFSET, 0, 1); `CHK(r[15:0], DECODE_RESET)
        wb(0, 8'h20, 0, 1); `CHK(r, 32'h0)
        wb(1, DST_OFFSET, 8'h5A, 0);
        wb(0, DST_OFFSET, 0, 1); `CHK(r[7:0], DATA_RESET)
        // Every opcode of columns 8 to F under fresh flags
        repeat (4) for (int k = 0; k < 128; k++) begin
            op = {k[3:0], 1'b1, k[6:4]};
            f = $urandom;
            wb(1, FLAGS_OFFSET, f, 1);
            wb(1, OPCODE_OFFSET, op, 1);
            j = (op[3:0] == 4'hB || op[3:0] == 4'hD) ? cond(op[7:4], f) : 1'b0;
            cls = (op[3:0] == 4'hF) ? 5'd8 + op[7:4] : op[3:0] - 4'd7;
            `CHK(jump_taken, j)
            wb(0, DECODE_OFFSET, 0, 1); `CHK(r[15:0], {10'h0, j, cls})
        end
        // Add with carry over all five encodings
        for (int k = 0; k < 80; k++) begin
            op = ADC_RR_OP + k % 5;
            d = $urandom; s = $urandom; f = $urandom;
            wb(1, DST_OFFSET, d, 1); wb(1, SRC_OFFSET, s, 1); wb(1, FLAGS_OFFSET, f, 1);
            wb(1, OPCODE_OFFSET, op, 1);
            {c9, sum} = d + s + f[7];
            ef = {c9, sum == 0, sum[7], d[7] == s[7] && sum[7] != d[7], 1'b0,
                  (d[3:0] + s[3:0] + f[7]) > 5'hF, f[1:0]};
            wb(0, DST_OFFSET, 0, 1); `CHK(r[7:0], sum)
            wb(0, RESULT_OFFSET, 0, 1); `CHK(r[7:0], sum)
            wb(0, SRC_OFFSET, 0, 1); `CHK(r[7:0], s)
            wb(0, FLAGS_OFFSET, 0, 1); `CHK(r[7:0], ef)
            wb(0, DECODE_OFFSET, 0, 1);
            `CHK(r[15:0], op < ADC_GG_OP ? 16'h6218 : (op < ADC_GIM_OP ? 16'hA358 : 16'hA318))
        end
        summarize();
    end
endmodule // cond_jump_decode_adc_tb
bind cond_jump_decode_adc cond_jump_decode_adc_chk chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .jump_taken(jump_taken));
